// >>> logic/wdtr_pkg.sv
// wdtr_pkg: shared constants and types of the watchdog with reset cause flags
package wdtr_pkg;
  // register byte addresses on the wishbone bus
  localparam logic [7:0] ADDR_CTRL = 8'h60;
  localparam logic [7:0] ADDR_CAUSE = 8'h64;
  // control register field positions
  localparam int B_IFLAG = 7;
  localparam int B_IEN = 6;
  localparam int B_P3 = 5;
  localparam int B_CE = 4;
  localparam int B_RE = 3;
  // cause register field positions
  localparam int B_WATCHDOG_RESET_CAUSE_FLAG = 3;
  localparam int B_BROWNOUT_CAUSE_FLAG = 2;
  localparam int B_EXTF = 1;
  localparam int B_POWER_ON_CAUSE_FLAG = 0;
  // cause flags after power-on: only the power-on flag set
  localparam logic [3:0] CAUSE_POR = 4'h1;
  localparam logic [3:0] PERIOD_RST = 4'h0;
  // change enable stays open for this many system clocks
  localparam logic [2:0] CE_WINDOW = 3'h4;
  // clock rates and the oscillator enable divider
  localparam int CLK_HZ = 40000000;
  localparam int OSC_HZ = 128000;
  localparam int OSC_DIV_DEF = CLK_HZ / OSC_HZ;
  // shortest period in oscillator cycles, highest legal code
  localparam int BASE_CYCLES_DEF = 2048;
  localparam logic [3:0] MAX_CODE = 4'h9;
  localparam int CNT_W = 21;
  // operating mode: {reset enable, interrupt enable}
  typedef enum logic [1:0] {
    WDTR_STOP = 2'b00,
    WDTR_INT = 2'b01,
    WDTR_RST = 2'b10,
    WDTR_INTRST = 2'b11
  } wdtr_mode_t;
endpackage

// >>> logic/wdtr_tick_if.sv
// wdtr_tick_if: carrier between the control logic and the timeout counter
`timescale 1ns/1ps
interface wdtr_tick_if;
  logic restart;
  logic run;
  logic [3:0] period;
  logic expired;
  modport ctrl (output restart, output run, output period, input expired);
  modport cnt (input restart, input run, input period, output expired);
endinterface

// >>> logic/wdtr_tick.sv
// wdtr_tick: oscillator enable divider and watchdog timeout counter
`timescale 1ns/1ps
module wdtr_tick import wdtr_pkg::*; #(
  parameter int OSC_DIV = OSC_DIV_DEF,
  parameter int BASE_CYCLES = BASE_CYCLES_DEF
) (
  input wire logic clock, // system clock
  input wire logic rst_n, // asynchronous reset, active low
  wdtr_tick_if.cnt tk // control side
);
  logic [15:0] div_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic osc_tick;
  logic [3:0] code;
  logic [CNT_W-1:0] limit;

  // reserved codes run at the longest period rather than stopping
  assign code = (tk.period > MAX_CODE) ? MAX_CODE : tk.period;
  assign limit = CNT_W'(BASE_CYCLES) << code;
  assign osc_tick = (div_reg == 16'(OSC_DIV - 1));

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= 16'h0000;
    end else if (osc_tick) begin
      div_reg <= 16'h0000;
    end else begin
      div_reg <= div_reg + 16'h0001;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
      tk.expired <= 1'b0;
    end else begin
      tk.expired <= 1'b0;
      if (tk.restart || !tk.run) begin
        cnt_reg <= '0;
      end else if (osc_tick) begin
        if (cnt_reg >= limit - CNT_W'(1)) begin
          cnt_reg <= '0;
          tk.expired <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg + CNT_W'(1);
        end
      end
    end
  end
endmodule

// >>> logic/wdtr_top.sv
// wdtr_top: watchdog timer with reset cause flags, wishbone register slave
//
// Functional notes
// - watchdog reset sets cause bit 3
// - brown-out reset sets cause bit 2
// - external reset sets cause bit 1
// - power-on sets bit 0, only software clears
// - cause bits 7:4 read zero
// - interrupt-mode timeout sets flag bit 7
// - interrupt needs flag, enable, global enable
// - reset and interrupt enables select mode
// - programmed always-on fuse forces reset mode
// - vector clears enable and flag, combined mode
// - unserviced interrupt, next timeout resets, combined mode
// - change enable gates protected writes, four clocks
// - watchdog cause flag forces reset enable
// - period code selects 2048 to 1048576
// - watchdog stays enabled after its reset
// - counter runs from a 128kHz enable divided down from the system clock
// - reset request lasts one system clock
//
// Implementation choice: the Wishbone slave port.
`timescale 1ns/1ps
module wdtr_top import wdtr_pkg::*; #(
  parameter int OSC_DIV = OSC_DIV_DEF,
  parameter int BASE_CYCLES = BASE_CYCLES_DEF
) (
  input wire logic clock, // system clock, 40 MHz
  input wire logic rst_n, // power-on reset, active low
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write
  input wire logic [7:0] wb_adr_i, // wishbone byte address
  input wire logic [3:0] wb_sel_i, // wishbone byte selects
  input wire logic [31:0] wb_dat_i, // wishbone write data
  output logic [31:0] wb_dat_o, // wishbone read data
  output logic wb_ack_o, // wishbone acknowledge
  input wire logic restart_cmd, // restart instruction executed
  input wire logic vector_taken, // watchdog vector executed
  input wire logic global_int_en, // processor global interrupt enable
  input wire logic always_on_fuse, // 0 = programmed
  input wire logic brownout_event, // brown-out reset occurred
  input wire logic ext_reset_event, // external pin reset occurred
  output logic irq_o, // watchdog interrupt request
  output logic sys_reset_req // one-cycle system reset request
);
  wdtr_tick_if tk ();

  logic ack_reg;
  logic [31:0] dat_reg;
  logic iflag_reg;
  logic ien_reg;
  logic re_reg;
  logic ce_reg;
  logic [2:0] ce_cnt_reg;
  logic [3:0] period_reg;
  logic [3:0] cause_reg;
  logic [3:0] cause_next;
  logic irq_reg;
  logic rreq_reg;

  logic bus_req;
  logic wr_fire;
  logic wr_ctrl;
  logic wr_cause;
  logic [7:0] wd;
  logic fuse_prog;
  logic re_eff;
  logic ien_eff;
  wdtr_mode_t mode;
  logic timeout;
  logic wdt_fire;
  logic other_rst;
  logic any_rst;
  logic set_iflag;
  logic ce_open;
  logic [7:0] ctrl_rd;

  // bus decode: writes land on the edge where the master sees ack
  assign bus_req = wb_cyc_i && wb_stb_i;
  assign wr_fire = bus_req && wb_we_i && ack_reg && wb_sel_i[0];
  assign wr_ctrl = wr_fire && (wb_adr_i == ADDR_CTRL);
  assign wr_cause = wr_fire && (wb_adr_i == ADDR_CAUSE);
  assign wd = wb_dat_i[7:0];

  assign fuse_prog = !always_on_fuse;
  assign re_eff = re_reg || cause_reg[B_WATCHDOG_RESET_CAUSE_FLAG] || fuse_prog;
  assign ien_eff = ien_reg && !fuse_prog;
  assign mode = fuse_prog ? WDTR_RST : wdtr_mode_t'({re_eff, ien_eff});

  assign timeout = tk.expired;
  // second timeout with flag pending resets
  assign wdt_fire = timeout && (mode == WDTR_RST ||
                    (mode == WDTR_INTRST && iflag_reg));
  // timeout in interrupt mode, or in combined mode with no flag pending, raises flag
  assign set_iflag = timeout && (mode == WDTR_INT ||
                     (mode == WDTR_INTRST && !iflag_reg));
  assign other_rst = brownout_event || ext_reset_event;
  assign any_rst = wdt_fire || other_rst;
  assign ce_open = wr_ctrl && wd[B_CE] && wd[B_RE];

  // restart on instruction or any reset
  assign tk.restart = restart_cmd || any_rst;
  assign tk.run = (mode != WDTR_STOP);
  assign tk.period = period_reg;

  wdtr_tick #(
    .OSC_DIV(OSC_DIV),
    .BASE_CYCLES(BASE_CYCLES)
  ) u_tick (
    .clock(clock),
    .rst_n(rst_n),
    .tk(tk)
  );

  // control register as read back, effective enables shown
  assign ctrl_rd = {iflag_reg, ien_eff, period_reg[3], ce_reg,
                    re_eff, period_reg[2:0]};

  // wishbone ack: one cycle, dropped the cycle after
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= bus_req && !ack_reg;
    end
  end

  // read data captured with the ack; unmapped reads return zero
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dat_reg <= 32'h00000000;
    end else if (bus_req && !ack_reg) begin
      if (wb_adr_i == ADDR_CTRL) begin
        dat_reg <= {24'h000000, ctrl_rd};
      end else if (wb_adr_i == ADDR_CAUSE) begin
        dat_reg <= {28'h0000000, cause_reg};
      end else begin
        dat_reg <= 32'h00000000;
      end
    end
  end

  // timeout interrupt flag; a set beats a same-cycle clear
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      iflag_reg <= 1'b0;
    end else if (any_rst) begin
      iflag_reg <= 1'b0;
    end else if (set_iflag) begin
      iflag_reg <= 1'b1;
    end else if (vector_taken || (wr_ctrl && wd[B_IFLAG])) begin
      iflag_reg <= 1'b0;
    end
  end

  // interrupt enable, writable at any time
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ien_reg <= 1'b0;
    end else if (any_rst) begin
      ien_reg <= 1'b0;
    end else if (wr_ctrl) begin
      ien_reg <= wd[B_IEN];
    end else if (vector_taken && mode == WDTR_INTRST) begin
      ien_reg <= 1'b0;
    end
  end

  // reset enable: setting is free, clearing needs the open window
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      re_reg <= 1'b0;
    end else if (any_rst) begin
      re_reg <= re_reg;
    end else if (cause_reg[B_WATCHDOG_RESET_CAUSE_FLAG]) begin
      // pinned while the cause flag stands, so a clear cannot slip through
      re_reg <= 1'b1;
    end else if (wr_ctrl) begin
      if (wd[B_RE]) begin
        re_reg <= 1'b1;
      end else if (ce_reg) begin
        re_reg <= 1'b0;
      end
    end
  end

  // change enable window, closed four clocks after opening
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ce_reg <= 1'b0;
      ce_cnt_reg <= 3'h0;
    end else if (any_rst) begin
      ce_reg <= 1'b0;
      ce_cnt_reg <= 3'h0;
    end else if (ce_open) begin
      ce_reg <= 1'b1;
      ce_cnt_reg <= CE_WINDOW;
    end else if (wr_ctrl) begin
      // the second step of the sequence consumes the window
      ce_reg <= 1'b0;
      ce_cnt_reg <= 3'h0;
    end else if (ce_reg) begin
      ce_cnt_reg <= ce_cnt_reg - 3'h1;
      if (ce_cnt_reg == 3'h1) begin
        ce_reg <= 1'b0;
      end
    end
  end

  // period select; a shorter period may time out at once
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      period_reg <= PERIOD_RST;
    end else if (any_rst) begin
      period_reg <= PERIOD_RST;
    end else if (wr_ctrl && ce_reg) begin
      period_reg <= {wd[B_P3], wd[2:0]};
    end
  end

  // cause flags: hardware sets win over a software clear
  always_comb begin
    cause_next = cause_reg;
    if (wr_cause) begin
      cause_next = cause_reg & wd[3:0];
    end
    if (wdt_fire) begin
      cause_next[B_WATCHDOG_RESET_CAUSE_FLAG] = 1'b1;
    end
    if (brownout_event) begin
      cause_next[B_BROWNOUT_CAUSE_FLAG] = 1'b1;
    end
    if (ext_reset_event) begin
      cause_next[B_EXTF] = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cause_reg <= CAUSE_POR;
    end else begin
      cause_reg <= cause_next;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= iflag_reg && ien_eff && global_int_en;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rreq_reg <= 1'b0;
    end else begin
      rreq_reg <= wdt_fire;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign irq_o = irq_reg;
  assign sys_reset_req = rreq_reg;

  // checks of the timer behaviour, all in the system clock domain
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  property p_watchdog_reset_cause_flag_set;
    wdt_fire |=> cause_reg[B_WATCHDOG_RESET_CAUSE_FLAG] && sys_reset_req;
  endproperty
  a_watchdog_reset_cause_flag_set: assert property (p_watchdog_reset_cause_flag_set) else $error("watchdog cause not set");

  property p_bor_set;
    brownout_event |=> cause_reg[B_BROWNOUT_CAUSE_FLAG];
  endproperty
  a_bor_set: assert property (p_bor_set) else $error("brown-out cause not set");

  property p_ext_set;
    ext_reset_event |=> cause_reg[B_EXTF];
  endproperty
  a_ext_set: assert property (p_ext_set) else $error("external cause not set");

  property p_por_keep;
    cause_reg[B_POWER_ON_CAUSE_FLAG] && !(wr_cause && !wd[B_POWER_ON_CAUSE_FLAG]) |=> cause_reg[B_POWER_ON_CAUSE_FLAG];
  endproperty
  a_por_keep: assert property (p_por_keep) else $error("power-on flag lost");

  property p_rsvd_zero;
    bus_req && !ack_reg && wb_adr_i == ADDR_CAUSE |=> wb_dat_o[31:4] == 28'h0000000;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits not zero");

  property p_irq_cause;
    irq_o |-> $past(iflag_reg) && $past(global_int_en) && $past(ien_eff);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without cause");

  property p_fuse_reset;
    fuse_prog && timeout |=> sys_reset_req && !iflag_reg;
  endproperty
  a_fuse_reset: assert property (p_fuse_reset) else $error("fuse mode no reset");

  property p_vec_clear;
    vector_taken && mode == WDTR_INTRST && !wr_ctrl && !timeout && !other_rst
      |=> !ien_reg && !iflag_reg;
  endproperty
  a_vec_clear: assert property (p_vec_clear) else $error("vector did not clear");

  property p_ce_window;
    ce_open && !any_rst ##1 (!wr_ctrl && !any_rst) [*4] |=> !ce_reg;
  endproperty
  a_ce_window: assert property (p_ce_window) else $error("change enable not closed");

  property p_re_forced;
    cause_reg[B_WATCHDOG_RESET_CAUSE_FLAG] |-> ctrl_rd[B_RE];
  endproperty
  a_re_forced: assert property (p_re_forced) else $error("reset enable not forced");

  property p_re_hold;
    cause_reg[B_WATCHDOG_RESET_CAUSE_FLAG] && !any_rst |=> re_reg;
  endproperty
  a_re_hold: assert property (p_re_hold) else $error("reset enable cleared under flag");

  property p_rreq_pulse;
    sys_reset_req |=> !sys_reset_req;
  endproperty
  a_rreq_pulse: assert property (p_rreq_pulse) else $error("reset pulse too long");

  c_int_timeout: cover property (set_iflag ##[1:3] irq_o);
  c_int_then_rst: cover property (set_iflag ##[1:1000] wdt_fire);
  c_protected: cover property (ce_open ##[1:4] (wr_ctrl && !wd[B_RE]));
  c_ack_read: cover property (bus_req && !wb_we_i ##1 wb_ack_o);
endmodule

// >>> test/tb_wdtr_top.sv
// tb_wdtr_top: self-checking bench of the watchdog with reset cause flags
`timescale 1ns/1ps
module tb_wdtr_top import wdtr_pkg::*;;
  localparam int DIV = 2;
  localparam int BASE = 4;
  logic clock, rst_n, cyc, stb, we, restart_cmd, vector_taken, global_int_en;
  logic always_on_fuse, brownout_event, ext_reset_event, irq_o, sys_reset_req, wb_ack_o;
  logic [7:0] adr;
  logic [31:0] dat, wb_dat_o, r;
  logic [15:0] lfsr_reg;
  logic [3:0] code;
  int fail_count, check_count, n, exp_len, got;
  // short divider and base keep the longest period near four thousand clocks
  wdtr_top #(.OSC_DIV(DIV), .BASE_CYCLES(BASE)) DUT (.clock(clock), .rst_n(rst_n),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .restart_cmd(restart_cmd),
    .vector_taken(vector_taken), .global_int_en(global_int_en),
    .always_on_fuse(always_on_fuse), .brownout_event(brownout_event),
    .ext_reset_event(ext_reset_event), .irq_o(irq_o), .sys_reset_req(sys_reset_req));
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // period code spread over bit 5 and bits 2:0
  function automatic logic [7:0] pb(input logic [3:0] c);
    return {2'b00, c[3], 2'b00, c[2:0]};
  endfunction
  function automatic int ticks(input logic [3:0] c);
    return BASE << ((c > 4'h9) ? 9 : c);
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one classic cycle; entered right after an edge, leaves after one idle edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    k = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h000000, d};
    do begin
      @(posedge clock);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 50);
    chk("ack", 32'h1, {31'h0, wb_ack_o});
    r = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(nm, {24'h000000, e}, r);
  endtask
  // open the change window, then the timed second write
  task automatic prot(input logic [7:0] v);
    bus(1'b1, ADDR_CTRL, 8'h18);
    bus(1'b1, ADDR_CTRL, v);
  endtask
  // bounded wait for the interrupt (0) or the reset request (1)
  task automatic wait_out(input bit rs, input int lim);
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (((rs ? sys_reset_req : irq_o) !== 1'b1) && n < lim);
    chk(rs ? "reset_req" : "irq", 32'h1, {31'h0, rs ? sys_reset_req : irq_o});
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // hang guard: the whole sequence needs well under forty thousand clocks
  initial begin
    repeat (60000) @(posedge clock);
    fail_count++;
    summarize();
  end
  initial begin
    {cyc, stb, we, vector_taken, brownout_event, ext_reset_event} = 6'h00;
    {rst_n, restart_cmd, global_int_en, always_on_fuse} = 4'h7;
    adr = 8'h00;
    dat = 32'h00000000;
    fail_count = 0;
    check_count = 0;
    lfsr_reg = 16'h9F95;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    // power-on flag alone, read before clearing
    rd("cause_por", ADDR_CAUSE, 8'h01);
    rd("ctrl_rst", ADDR_CTRL, 8'h00);
    restart_cmd <= 1'b0;
    repeat (40) @(posedge clock);
    chk("stop_quiet", 32'h0, {30'h0, irq_o, sys_reset_req});
    bus(1'b1, 8'h10, 8'hFF);
    rd("unmapped", 8'h10, 8'h00);
    // other reset kinds set their flags, keep power-on
    brownout_event <= 1'b1;
    @(posedge clock);
    brownout_event <= 1'b0;
    ext_reset_event <= 1'b1;
    @(posedge clock);
    ext_reset_event <= 1'b0;
    bus(1'b1, ADDR_CAUSE, 8'hFF);
    rd("cause_be", ADDR_CAUSE, 8'h07);
    bus(1'b1, ADDR_CAUSE, 8'h00);
    rd("cause_clr", ADDR_CAUSE, 8'h00);
    // restarts inside the period hold off the timeout
    bus(1'b1, ADDR_CTRL, 8'h40);
    restart_cmd <= 1'b0;
    repeat (12) begin
      repeat (3) @(posedge clock);
      restart_cmd <= 1'b1;
      @(posedge clock);
      restart_cmd <= 1'b0;
      chk("irq_held", 32'h0, {31'h0, irq_o});
    end
    // interrupt mode sets the flag and asks only with global enable
    wait_out(1'b0, 40);
    restart_cmd <= 1'b1;
    global_int_en <= 1'b0;
    rd("ctrl_flag", ADDR_CTRL, 8'hC0);
    chk("irq_gie", 32'h0, {31'h0, irq_o});
    global_int_en <= 1'b1;
    bus(1'b1, ADDR_CTRL, 8'hC0);
    @(posedge clock);
    chk("irq_w1c", 32'h0, {31'h0, irq_o});
    // timeout length for corner and random period codes
    for (int i = 0; i < 6; i++) begin
      lfsr_reg = lfsr(lfsr_reg);
      code = (i == 0) ? 4'h0 : (i == 1) ? 4'h9 : (i == 2) ? 4'hA : 4'(lfsr_reg % 10);
      // counter held by restart across the timed change
      prot(8'h40 | pb(code));
      restart_cmd <= 1'b0;
      wait_out(1'b0, 5000);
      restart_cmd <= 1'b1;
      exp_len = DIV * ticks(code);
      got = (n >= exp_len - 4 && n <= exp_len + 6) ? exp_len : n;
      chk("period_len", 32'(exp_len), 32'(got));
      bus(1'b1, ADDR_CTRL, 8'h80);
    end
    // vector clears enable and flag, next timeout resets
    bus(1'b1, ADDR_CTRL, 8'h48);
    restart_cmd <= 1'b0;
    wait_out(1'b0, 5000);
    vector_taken <= 1'b1;
    @(posedge clock);
    vector_taken <= 1'b0;
    rd("ctrl_vec", ADDR_CTRL, 8'h08 | pb(code));
    wait_out(1'b1, 5000);
    restart_cmd <= 1'b1;
    @(posedge clock);
    chk("req_pulse", 32'h0, {31'h0, sys_reset_req});
    rd("cause_wdt", ADDR_CAUSE, 8'h08);
    rd("ctrl_kept", ADDR_CTRL, 8'h08);
    // the cause flag pins reset enable until cleared
    prot(8'h00);
    rd("ctrl_forced", ADDR_CTRL, 8'h08);
    bus(1'b1, ADDR_CAUSE, 8'h00);
    // no window, a late window, then a proper sequence
    bus(1'b1, ADDR_CTRL, 8'h00);
    rd("ctrl_noce", ADDR_CTRL, 8'h08);
    bus(1'b1, ADDR_CTRL, 8'h18);
    repeat (6) @(posedge clock);
    bus(1'b1, ADDR_CTRL, 8'h00);
    rd("ctrl_late", ADDR_CTRL, 8'h08);
    prot(8'h00);
    rd("ctrl_off", ADDR_CTRL, 8'h00);
    // unserviced interrupt in combined mode ends in a reset
    bus(1'b1, ADDR_CTRL, 8'h48);
    restart_cmd <= 1'b0;
    wait_out(1'b0, 40);
    wait_out(1'b1, 40);
    restart_cmd <= 1'b1;
    // clear cause flag, then reset enable
    bus(1'b1, ADDR_CAUSE, 8'h00);
    prot(8'h00);
    always_on_fuse <= 1'b0;
    @(posedge clock);
    rd("ctrl_fuse", ADDR_CTRL, 8'h08);
    restart_cmd <= 1'b0;
    wait_out(1'b1, 40);
    summarize();
  end
endmodule
